//--- core/cdr_rate_lock_defines.vh
`ifndef CDR_RATE_LOCK_DEFINES_VH
`define CDR_RATE_LOCK_DEFINES_VH

// register offsets, per channel except the shared channel select
`define REG_LOCK_STAT  8'h01
`define REG_CDR_RESET  8'h0A
`define REG_RATE_STD   8'h2F
`define REG_REF_MODE   8'h36
`define REG_G0_LO      8'h60
`define REG_G0_HI      8'h61
`define REG_G1_LO      8'h62
`define REG_G1_HI      8'h63
`define REG_TOL        8'h64
`define REG_CHAN_SEL   8'hFF

// reset values
`define RST_RATE_STD   8'h02
`define RST_REF_MODE   8'h30
`define RST_ZERO       8'h00

// field positions
`define F_RATE_CODE    7:4
`define F_FLD_DIS      1
`define F_REF_MODE     5:4
`define F_FORCE_DIV    1:0
`define F_CDR_RST      3:2
`define F_MANUAL       7
`define F_CNT_HI       6:0
`define F_TOL_G0       3:0
`define F_TOL_G1       7:4
`define F_CHAN_IDX     1:0
`define F_CHAN_ALL     2

// field values
`define REF_ASSIST     2'h3

// timing and search counts, default bus address
`define REF_WINDOW     16'h03E8
`define CT_SPAN        5'h04
`define SMB_ADDR_DFLT  7'h18

`endif

//--- core/rate_window_counter.v
`timescale 1ns/1ps
`default_nettype none
`include "cdr_rate_lock_defines.vh"

module rate_window_counter
#(
	parameter [15:0] WIN_REF = `REF_WINDOW
)
(
	input  wire        i_clock,
	input  wire        i_rst_n,
	input  wire        i_ref_clk,
	input  wire        i_tick,
	input  wire        i_start,
	output reg         o_done,
	output reg  [15:0] o_count
);

	reg        ref_q_r;
	reg        busy_r;
	reg [15:0] ref_cnt_r;
	reg [15:0] acc_r;

	// ref sampled at twice its rate; relies on a near 50 % duty cycle
	wire        ref_rise = i_ref_clk & ~ref_q_r;
	// saturate so an overspeed input never wraps into tolerance
	wire [15:0] acc_nxt  = (&acc_r) ? acc_r : acc_r + {15'h0000, i_tick};

	// window of WIN_REF reference periods, count of rate ticks inside it
	always @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			ref_q_r   <= 1'h0;
			busy_r    <= 1'h0;
			ref_cnt_r <= 16'h0000;
			acc_r     <= 16'h0000;
			o_done    <= 1'h0;
			o_count   <= 16'h0000;
		end
		else
		begin
			ref_q_r <= i_ref_clk;
			o_done  <= 1'h0;
			if (i_start)
			begin
				busy_r    <= 1'h1;
				ref_cnt_r <= 16'h0000;
				acc_r     <= 16'h0000;
			end
			else if (busy_r)
			begin
				acc_r <= acc_nxt;
				if (ref_rise && ref_cnt_r == WIN_REF - 16'h0001)
				begin
					busy_r  <= 1'h0;
					o_done  <= 1'h1;
					o_count <= acc_nxt;
				end
				else if (ref_rise)
					ref_cnt_r <= ref_cnt_r + 16'h0001;
			end
		end
	end

endmodule
`default_nettype wire

//--- core/cdr_lock_engine.v
`timescale 1ns/1ps
`default_nettype none
`include "cdr_rate_lock_defines.vh"

module cdr_lock_engine
#(
	parameter [4:0] SPAN = `CT_SPAN
)
(
	input  wire        i_clock,
	input  wire        i_rst_n,
	input  wire        i_restart,
	input  wire        i_ref_ok,
	input  wire [3:0]  i_rate_code,
	input  wire        i_fld_dis,
	input  wire [1:0]  i_force_div,
	input  wire [14:0] i_exp0,
	input  wire        i_man0,
	input  wire [14:0] i_exp1,
	input  wire        i_man1,
	input  wire [3:0]  i_tol0,
	input  wire [3:0]  i_tol1,
	input  wire        i_meas_done,
	input  wire [15:0] i_meas_cnt,
	output wire        o_meas_start,
	output reg  [1:0]  o_div_sel,
	output reg  [4:0]  o_vco_capacitor_trim,
	output reg         o_group,
	output wire        o_lock,
	output wire        o_search
);

	localparam [3:0] S_IDLE = 4'h1;
	localparam [3:0] S_SET  = 4'h2;
	localparam [3:0] S_MEAS = 4'h4;
	localparam [3:0] S_LOCK = 4'h8;

	// allowed dividers, bit k means divide by 2**k
	function [3:0] div_mask;
		input [3:0] code;
		input       grp;
		begin
			case (code)
				4'h2, 4'h3: div_mask = 4'h7;
				4'h4:       div_mask = 4'h6;
				4'h6:       div_mask = 4'hF;
				4'hA:       div_mask = 4'h2;
				4'hB:       div_mask = 4'h6;
				4'hC:       div_mask = 4'h1;
				4'hF:       div_mask = grp ? 4'h1 : 4'h8;
				default:    div_mask = 4'h0;
			endcase
		end
	endfunction

	reg [3:0] state_r;
	reg [4:0] step_r;
	reg       pass_r;

	// standards mode when the code is one of the known ones
	wire        std_mode = div_mask(i_rate_code, 1'h0) != 4'h0;
	wire [3:0]  mask     = std_mode ? div_mask(i_rate_code, o_group) : (4'h1 << i_force_div);
	wire [4:0]  lim      = std_mode ? SPAN - 5'h01 : 5'h1F;
	wire [4:0]  trim_nxt = std_mode ? {1'h0, i_rate_code} + step_r : step_r;
	wire        man      = o_group ? i_man1 : i_man0;
	wire        cand_ok  = mask[o_div_sel] & man;
	// each group keeps its own expected count and tolerance
	wire [15:0] exp_cnt  = {1'h0, o_group ? i_exp1 : i_exp0};
	wire [3:0]  tol      = o_group ? i_tol1 : i_tol0;
	wire [15:0] diff     = (i_meas_cnt >= exp_cnt) ? i_meas_cnt - exp_cnt : exp_cnt - i_meas_cnt;
	wire        in_tol   = diff <= {12'h000, tol};
	// next candidate: trim step, then divider, then group
	wire        step_end = step_r >= lim;
	wire [4:0]  step_nxt = step_end ? 5'h00 : step_r + 5'h01;
	wire [1:0]  div_nxt  = step_end ? o_div_sel + 2'h1 : o_div_sel;
	wire        grp_nxt  = (step_end && o_div_sel == 2'h3) ? ~o_group : o_group;
	wire        watching = state_r == S_MEAS || state_r == S_LOCK;

	assign o_meas_start = (state_r == S_SET && cand_ok) || (i_meas_done && in_tol && watching);
	assign o_lock       = state_r == S_LOCK;
	assign o_search     = state_r == S_SET || state_r == S_MEAS;

	// acquisition search; a failed window moves on with no host action
	always @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			state_r              <= S_IDLE;
			step_r               <= 5'h00;
			pass_r               <= 1'h0;
			o_div_sel            <= 2'h0;
			o_group              <= 1'h0;
			o_vco_capacitor_trim <= 5'h00;
		end
		else
		begin
			o_vco_capacitor_trim <= trim_nxt;
			if (i_restart || !i_ref_ok)
			begin
				state_r <= S_IDLE;
				pass_r  <= 1'h0;
			end
			else
			begin
				case (state_r)
					S_IDLE:
					begin
						step_r    <= 5'h00;
						o_div_sel <= 2'h0;
						o_group   <= 1'h0;
						state_r   <= S_SET;
					end
					S_SET:
					begin
						if (cand_ok)
							state_r <= S_MEAS;
						else
						begin
							step_r    <= step_nxt;
							o_div_sel <= div_nxt;
							o_group   <= grp_nxt;
						end
					end
					S_MEAS:
					begin
						if (i_meas_done && in_tol)
						begin
							pass_r <= 1'h1;
							if (i_fld_dis || pass_r)
								state_r <= S_LOCK;
						end
						else if (i_meas_done)
						begin
							pass_r    <= 1'h0;
							step_r    <= step_nxt;
							o_div_sel <= div_nxt;
							o_group   <= grp_nxt;
							state_r   <= S_SET;
						end
					end
					S_LOCK:
					begin
						if (i_meas_done && !in_tol)
						begin
							pass_r    <= 1'h0;
							step_r    <= step_nxt;
							o_div_sel <= div_nxt;
							o_group   <= grp_nxt;
							state_r   <= S_SET;
						end
					end
					default:
						state_r <= S_IDLE;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

//--- core/cdr_rate_lock_config.v
`timescale 1ns/1ps
`default_nettype none
`include "cdr_rate_lock_defines.vh"

// Notes on behaviour
// - a known rate code narrows coarse tuning and dividers to that standard's set
// - rate code nibble all ones picks dividers itself for 10.3125 or 1.25 Gb/s
// - in standards mode the allowed dividers are walked with no further writes
// - group 0 count at group0_count_low/group0_count_high, group 1 at group1_count_low/group1_count_high, tolerance at count_tolerance
// - low byte in low register, seven upper bits plus manual flag in high
// - tolerance register holds two four-bit tolerances, one per nibble
// - expected counts and tolerance together qualify frequency lock
// - range mode uses one fixed divider, one unless forced otherwise
// - channel select register steers later per-channel accesses
// - reference mode field equal to three enables reference-assisted lock
// - setting then clearing reset bits restarts acquisition on that channel
// - after setup a matching input rate is locked to
// - in reference mode the capacitor trim is searched by the device
// - rate code table maps to allowed dividers for each group
// - groups keep separate counts even when sharing a divider set
// - reference mode field resets to three
// - false-lock guard bit resets to one, disabling the guard

module cdr_rate_lock_config
#(
	parameter [6:0]  SMB_ADDR = `SMB_ADDR_DFLT,
	parameter        NUM_CH   = 4,
	parameter [15:0] WIN_REF  = `REF_WINDOW
)
(
	input  wire                  i_clock,
	input  wire                  i_rst_n,
	input  wire                  i_smb_clk,
	input  wire                  i_smb_data_in,
	output wire                  o_smb_data_out,
	output wire                  o_smb_data_oe,
	input  wire                  i_ref_clk,
	input  wire [NUM_CH-1:0]     i_rate_tick,
	output wire [NUM_CH-1:0]     o_lock,
	output wire [NUM_CH-1:0]     o_group,
	output wire [2*NUM_CH-1:0]   o_div_sel,
	output wire [5*NUM_CH-1:0]   o_vco_capacitor_trim
);

	localparam [6:0] ST_IDLE = 7'h01;
	localparam [6:0] ST_ADDR = 7'h02;
	localparam [6:0] ST_CMD  = 7'h04;
	localparam [6:0] ST_DATA = 7'h08;
	localparam [6:0] ST_ACK  = 7'h10;
	localparam [6:0] ST_RD   = 7'h20;
	localparam [6:0] ST_RACK = 7'h40;

	reg  [6:0]          st_r;
	reg  [6:0]          after_ack_r;
	reg  [7:0]          sh_r;
	reg  [3:0]          cnt_r;
	reg  [7:0]          cmd_r;
	reg                 oe_r;
	reg                 scl_q_r;
	reg                 sda_q_r;
	reg  [7:0]          chan_r;
	reg  [7:0]          rd_data;
	wire [8*NUM_CH-1:0] rd_bus;

	// bus conditions; pins arrive synchronous so one stored sample is enough
	wire scl_rise  = i_smb_clk & ~scl_q_r;
	wire scl_fall  = ~i_smb_clk & scl_q_r;
	wire bus_start = i_smb_clk & scl_q_r & sda_q_r & ~i_smb_data_in;
	wire bus_stop  = i_smb_clk & scl_q_r & ~sda_q_r & i_smb_data_in;
	wire byte_end  = scl_fall && cnt_r == 4'h8;
	wire wr_en     = st_r == ST_DATA && byte_end;

	// open drain: the line is only ever pulled low
	assign o_smb_data_out = 1'h0;
	assign o_smb_data_oe  = oe_r;

	// previous pin levels; idle bus reads high
	always @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			scl_q_r <= 1'h1;
			sda_q_r <= 1'h1;
		end
		else
		begin
			scl_q_r <= i_smb_clk;
			sda_q_r <= i_smb_data_in;
		end
	end

	// byte-level slave: write byte and read byte with repeated start
	always @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			st_r        <= ST_IDLE;
			after_ack_r <= ST_IDLE;
			sh_r        <= 8'h00;
			cnt_r       <= 4'h0;
			cmd_r       <= 8'h00;
			oe_r        <= 1'h0;
		end
		else if (bus_stop)
		begin
			st_r <= ST_IDLE;
			oe_r <= 1'h0;
		end
		else if (bus_start)
		begin
			st_r  <= ST_ADDR;
			cnt_r <= 4'h0;
			oe_r  <= 1'h0;
		end
		else
		begin
			case (st_r)
				ST_ADDR, ST_CMD, ST_DATA:
				begin
					if (scl_rise)
					begin
						sh_r  <= {sh_r[6:0], i_smb_data_in};
						cnt_r <= cnt_r + 4'h1;
					end
					else if (byte_end)
					begin
						cnt_r <= 4'h0;
						st_r  <= ST_ACK;
						oe_r  <= 1'h1;
						if (st_r == ST_ADDR)
						begin
							after_ack_r <= sh_r[0] ? ST_RD : ST_CMD;
							// foreign address: stay silent until the next start
							if (sh_r[7:1] != SMB_ADDR)
							begin
								st_r <= ST_IDLE;
								oe_r <= 1'h0;
							end
						end
						else if (st_r == ST_CMD)
						begin
							cmd_r       <= sh_r;
							after_ack_r <= ST_DATA;
						end
						else
							after_ack_r <= ST_DATA;
					end
				end
				ST_ACK:
				begin
					if (scl_fall)
					begin
						st_r  <= after_ack_r;
						cnt_r <= 4'h0;
						if (after_ack_r == ST_RD)
						begin
							sh_r <= rd_data;
							oe_r <= ~rd_data[7];
						end
						else
							oe_r <= 1'h0;
					end
				end
				ST_RD:
				begin
					if (scl_fall)
					begin
						cnt_r <= cnt_r + 4'h1;
						sh_r  <= {sh_r[6:0], 1'h0};
						if (cnt_r == 4'h7)
						begin
							oe_r <= 1'h0;
							st_r <= ST_RACK;
						end
						else
							oe_r <= ~sh_r[6];
					end
				end
				ST_RACK:
				begin
					// master ack repeats the same register, nack ends the read
					if (scl_rise && i_smb_data_in)
						st_r <= ST_IDLE;
					else if (scl_rise)
					begin
						st_r        <= ST_ACK;
						after_ack_r <= ST_RD;
					end
				end
				ST_IDLE:
					st_r <= ST_IDLE;
				default:
					st_r <= ST_IDLE;
			endcase
		end
	end

	// shared channel selector, written from any channel context
	always @(posedge i_clock)
	begin
		if (!i_rst_n)
			chan_r <= `RST_ZERO;
		else if (wr_en && cmd_r == `REG_CHAN_SEL)
			chan_r <= sh_r;
	end

	// read mux: selector itself, else the addressed channel
	always @*
	begin
		if (cmd_r == `REG_CHAN_SEL)
			rd_data = chan_r;
		else
			rd_data = rd_bus[{chan_r[`F_CHAN_IDX], 3'h0} +: 8];
	end

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch = ch + 1)
		begin : g_ch
			// integer index cut to the two selector bits on purpose
			localparam [31:0] CH_NUM = ch;
			localparam [1:0]  CH_ID  = CH_NUM[1:0];

			reg  [7:0]  rst_ctl_r;
			reg  [7:0]  rate_r;
			reg  [7:0]  ref_r;
			reg  [7:0]  g0_lo_r;
			reg  [7:0]  g0_hi_r;
			reg  [7:0]  g1_lo_r;
			reg  [7:0]  g1_hi_r;
			reg  [7:0]  tol_r;
			reg  [7:0]  rd_w;
			wire        meas_done;
			wire        meas_start;
			wire [15:0] meas_cnt;
			wire        searching;

			// broadcast bit writes every channel at once
			wire hit = wr_en && (chan_r[`F_CHAN_ALL] || chan_r[`F_CHAN_IDX] == CH_ID);

			// per-channel configuration registers
			always @(posedge i_clock)
			begin
				if (!i_rst_n)
				begin
					rst_ctl_r <= `RST_ZERO;
					rate_r    <= `RST_RATE_STD;
					ref_r     <= `RST_REF_MODE;
					g0_lo_r   <= `RST_ZERO;
					g0_hi_r   <= `RST_ZERO;
					g1_lo_r   <= `RST_ZERO;
					g1_hi_r   <= `RST_ZERO;
					tol_r     <= `RST_ZERO;
				end
				else if (hit)
				begin
					if (cmd_r == `REG_CDR_RESET)
						rst_ctl_r <= sh_r;
					else if (cmd_r == `REG_RATE_STD)
						rate_r <= sh_r;
					else if (cmd_r == `REG_REF_MODE)
						ref_r <= sh_r;
					else if (cmd_r == `REG_G0_LO)
						g0_lo_r <= sh_r;
					else if (cmd_r == `REG_G0_HI)
						g0_hi_r <= sh_r;
					else if (cmd_r == `REG_G1_LO)
						g1_lo_r <= sh_r;
					else if (cmd_r == `REG_G1_HI)
						g1_hi_r <= sh_r;
					else if (cmd_r == `REG_TOL)
						tol_r <= sh_r;
				end
			end

			// read back; unmapped offsets read zero
			always @*
			begin
				if (cmd_r == `REG_LOCK_STAT)
					rd_w = {3'h0, o_group[ch], o_div_sel[2*ch +: 2], searching, o_lock[ch]};
				else if (cmd_r == `REG_CDR_RESET)
					rd_w = rst_ctl_r;
				else if (cmd_r == `REG_RATE_STD)
					rd_w = rate_r;
				else if (cmd_r == `REG_REF_MODE)
					rd_w = ref_r;
				else if (cmd_r == `REG_G0_LO)
					rd_w = g0_lo_r;
				else if (cmd_r == `REG_G0_HI)
					rd_w = g0_hi_r;
				else if (cmd_r == `REG_G1_LO)
					rd_w = g1_lo_r;
				else if (cmd_r == `REG_G1_HI)
					rd_w = g1_hi_r;
				else if (cmd_r == `REG_TOL)
					rd_w = tol_r;
				else
					rd_w = 8'h00;
			end

			assign rd_bus[8*ch +: 8] = rd_w;

			// recovered-rate count over a reference-timed window
			rate_window_counter #(
				.WIN_REF (WIN_REF)
			) u_meas (
				.i_clock   (i_clock),
				.i_rst_n   (i_rst_n),
				.i_ref_clk (i_ref_clk),
				.i_tick    (i_rate_tick[ch]),
				.i_start   (meas_start),
				.o_done    (meas_done),
				.o_count   (meas_cnt)
			);

			// acquisition held off while either reset bit stands
			cdr_lock_engine #(
				.SPAN (`CT_SPAN)
			) u_lock (
				.i_clock              (i_clock),
				.i_rst_n              (i_rst_n),
				.i_restart            (|rst_ctl_r[`F_CDR_RST]),
				.i_ref_ok             (ref_r[`F_REF_MODE] == `REF_ASSIST),
				.i_rate_code          (rate_r[`F_RATE_CODE]),
				.i_fld_dis            (rate_r[`F_FLD_DIS]),
				.i_force_div          (ref_r[`F_FORCE_DIV]),
				.i_exp0               ({g0_hi_r[`F_CNT_HI], g0_lo_r}),
				.i_man0               (g0_hi_r[`F_MANUAL]),
				.i_exp1               ({g1_hi_r[`F_CNT_HI], g1_lo_r}),
				.i_man1               (g1_hi_r[`F_MANUAL]),
				.i_tol0               (tol_r[`F_TOL_G0]),
				.i_tol1               (tol_r[`F_TOL_G1]),
				.i_meas_done          (meas_done),
				.i_meas_cnt           (meas_cnt),
				.o_meas_start         (meas_start),
				.o_div_sel            (o_div_sel[2*ch +: 2]),
				.o_vco_capacitor_trim (o_vco_capacitor_trim[5*ch +: 5]),
				.o_group              (o_group[ch]),
				.o_lock               (o_lock[ch]),
				.o_search             (searching)
			);
		end
	endgenerate

endmodule
`default_nettype wire

//--- verif/cdr_rate_lock_config_chk.sv
`timescale 1ns/1ps
`default_nettype none
// lock and bus pin checks on the top level
module cdr_rate_lock_config_chk
#(
	parameter NUM_CH = 4
)
(
	input wire logic                i_clock,
	input wire logic                i_rst_n,
	input wire logic                i_smb_clk,
	input wire logic                i_ref_clk,
	input wire logic                o_smb_data_out,
	input wire logic                o_smb_data_oe,
	input wire logic [NUM_CH-1:0]   o_lock,
	input wire logic [NUM_CH-1:0]   o_group,
	input wire logic [2*NUM_CH-1:0] o_div_sel,
	input wire logic [5*NUM_CH-1:0] o_vco_capacitor_trim
);
	logic [3:0] low_cnt_r;
	logic [3:0] ref_gap_r;
	// saturating counts of bus clock low time and reference idle time
	always_ff @(posedge i_clock)
	begin
		low_cnt_r <= i_smb_clk ? 4'h0 : low_cnt_r + {3'h0, low_cnt_r != 4'hF};
		ref_gap_r <= i_ref_clk ? 4'h0 : ref_gap_r + {3'h0, ref_gap_r != 4'hF};
	end
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	// two locked samples in a row: the search must be parked
	sequence s_locked2;
		o_lock[0] ##1 o_lock[0];
	endsequence
	property p_out_low;
		o_smb_data_out == 1'b0;
	endproperty
	property p_rst_quiet;
		$rose(i_rst_n) |-> o_lock == '0 && !o_smb_data_oe && o_group == '0 && o_div_sel == '0
			&& o_vco_capacitor_trim == '0;
	endproperty
	// the data line may only move while the bus clock is low, and soon after its fall
	property p_oe_clk_low;
		$past(i_rst_n) && $changed(o_smb_data_oe) |-> !i_smb_clk;
	endproperty
	property p_oe_prompt;
		$past(i_rst_n) && $changed(o_smb_data_oe) |-> low_cnt_r inside {[4'h1:4'h4]};
	endproperty
	property p_hold_div;
		s_locked2 |-> $stable(o_div_sel[1:0]);
	endproperty
	property p_hold_grp;
		s_locked2 |-> $stable(o_group[0]);
	endproperty
	property p_hold_trim;
		s_locked2 |-> $stable(o_vco_capacitor_trim[4:0]);
	endproperty
	property p_lock_ref;
		$rose(o_lock[0]) |-> ref_gap_r < 4'h4;
	endproperty
	a_out_low: assert property (p_out_low) else $error("data output driven high");
	a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not cleared by reset");
	a_oe_clk_low: assert property (p_oe_clk_low) else $error("data moved with clock high");
	a_oe_prompt: assert property (p_oe_prompt) else $error("data moved late after clock fall");
	a_hold_div: assert property (p_hold_div) else $error("divider moved while locked");
	a_hold_grp: assert property (p_hold_grp) else $error("group moved while locked");
	a_hold_trim: assert property (p_hold_trim) else $error("trim moved while locked");
	a_lock_ref: assert property (p_lock_ref) else $error("lock without reference edges");
endmodule
bind cdr_rate_lock_config cdr_rate_lock_config_chk #(.NUM_CH(NUM_CH)) i_chk (.i_clock(i_clock), .i_rst_n(i_rst_n),
	.i_smb_clk(i_smb_clk), .i_ref_clk(i_ref_clk), .o_smb_data_out(o_smb_data_out), .o_smb_data_oe(o_smb_data_oe),
	.o_lock(o_lock), .o_group(o_group), .o_div_sel(o_div_sel), .o_vco_capacitor_trim(o_vco_capacitor_trim));
`default_nettype wire

//--- verif/smb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// configuring host on the two-wire bus; data has a pull-up, so released reads high
module smb_host_model
(
	input  wire logic i_clock,
	input  wire logic i_sda,
	output var  logic o_scl,
	output var  logic o_sda_low
);
	// both lines idle released; clock stands still between frames
	initial
	begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	// four system cycles a phase keeps well above the two-cycle minimum
	task step;
		repeat (4) @(posedge i_clock);
		#1;
	endtask
	// data set in mid low phase, answer taken at the end of the high phase
	task bit_io(input logic b, output logic r);
		o_scl = 1'b0;
		step;
		o_sda_low = !b;
		step;
		o_scl = 1'b1;
		step;
		r = i_sda;
	endtask
	task byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(1'b1, ack);
		ack = !ack;
	endtask
	// repeated start first drops the clock so the device lets go of data
	task start(input logic rep);
		if (rep)
		begin
			o_scl = 1'b0;
			step;
		end
		o_sda_low = 1'b0;
		step;
		o_scl = 1'b1;
		step;
		o_sda_low = 1'b1;
		step;
	endtask
	task stop;
		o_scl = 1'b0;
		step;
		o_sda_low = 1'b1;
		step;
		o_scl = 1'b1;
		step;
		o_sda_low = 1'b0;
		step;
	endtask
	task write_reg(input logic [6:0] adr, input logic [7:0] off, input logic [7:0] d, output logic ok);
		logic [7:0] q;
		logic a0, a1, a2;
		start(1'b0);
		byte_io({adr, 1'b0}, q, a0);
		byte_io(off, q, a1);
		byte_io(d, q, a2);
		stop;
		ok = a0 & a1 & a2;
	endtask
	// single byte read, closed by a not-acknowledge
	task read_reg(input logic [6:0] adr, input logic [7:0] off, output logic [7:0] q);
		logic [7:0] x;
		logic a;
		start(1'b0);
		byte_io({adr, 1'b0}, x, a);
		byte_io(off, x, a);
		start(1'b1);
		byte_io({adr, 1'b1}, x, a);
		byte_io(8'hFF, q, a);
		stop;
	endtask
endmodule
`default_nettype wire

//--- verif/cdr_rate_lock_config_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "cdr_rate_lock_defines.vh"
`define CHECK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("Error %0t: %h not %h", $time, g, e); end end
module cdr_rate_lock_config_bench;
	logic        i_clock;
	logic        i_rst_n;
	logic        ref_clk;
	logic        tick_ph;
	logic [3:0]  tick_en;
	logic [7:0]  q;
	logic        ok;
	int          n_fail;
	int          n_checks;
	wire         scl;
	wire         host_low;
	wire         dout;
	wire         oe;
	wire         sda;
	wire  [3:0]  lock;
	wire  [3:0]  grp;
	wire  [7:0]  div;
	wire  [19:0] trim;
	// open-drain data line with pull-up
	assign sda = !(host_low || (oe && !dout));
	cdr_rate_lock_config #(.WIN_REF(16'h0004)) i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_smb_clk(scl),
		.i_smb_data_in(sda), .o_smb_data_out(dout), .o_smb_data_oe(oe), .i_ref_clk(ref_clk),
		.i_rate_tick(tick_en & {4{tick_ph}}), .o_lock(lock), .o_group(grp), .o_div_sel(div),
		.o_vco_capacitor_trim(trim));
	smb_host_model i_host (.i_clock(i_clock), .i_sda(sda), .o_scl(scl), .o_sda_low(host_low));
	// system clock, and a 25 MHz reference moved 1 ns off the system edge
	initial
	begin
		i_clock = 1'b0;
		forever #10 i_clock = !i_clock;
	end
	initial
	begin
		ref_clk = 1'b0;
		#11;
		forever #20 ref_clk = !ref_clk;
	end
	// a rate tick every other cycle gives about four counts per window
	always @(posedge i_clock)
		tick_ph <= #1 !tick_ph;
	task wr(input logic [7:0] off, input logic [7:0] d);
		i_host.write_reg(`SMB_ADDR_DFLT, off, d, ok);
		`CHECK(ok, 1'b1)
	endtask
	task rd_chk(input logic [7:0] off, input logic [7:0] e);
		i_host.read_reg(`SMB_ADDR_DFLT, off, q);
		`CHECK(q, e)
	endtask
	task restart;
		wr(`REG_CDR_RESET, 8'h0C);
		wr(`REG_CDR_RESET, 8'h00);
	endtask
	// host order: reference, rate code, counts, tolerance, then restart
	task setup(input logic [7:0] rate, input logic [15:0] c0, input logic [15:0] c1, input logic [7:0] tol);
		wr(`REG_REF_MODE, 8'h30);
		wr(`REG_RATE_STD, rate);
		wr(`REG_G0_LO, c0[7:0]);
		wr(`REG_G0_HI, c0[15:8]);
		wr(`REG_G1_LO, c1[7:0]);
		wr(`REG_G1_HI, c1[15:8]);
		wr(`REG_TOL, tol);
		restart;
	endtask
	// bounded wait for a lock level; the other watches a span for any lock at all
	task wait_lock(input int ch, input logic e);
		int n;
		n = 0;
		while (lock[ch] !== e && n < 600)
		begin
			@(posedge i_clock);
			n++;
		end
		#1;
		`CHECK(lock[ch], e)
	endtask
	task no_lock(input int ch);
		logic seen;
		seen = 1'b0;
		repeat (400)
		begin
			@(posedge i_clock);
			#1;
			seen = seen | lock[ch];
		end
		`CHECK(seen, 1'b0)
	endtask
	// rate in units of 0.1 Mb/s, integer part kept
	function automatic logic [14:0] rate_count(input int r);
		return 15'(r * 1280 / 10000);
	endfunction
	task t_reset;
		rd_chk(`REG_RATE_STD, 8'h02);
		rd_chk(`REG_REF_MODE, 8'h30);
		i_host.write_reg(`SMB_ADDR_DFLT ^ 7'h01, `REG_TOL, 8'h11, ok);
		`CHECK(ok, 1'b0)
		wr(8'h10, 8'h5A);
		rd_chk(8'h10, 8'h00);
		rd_chk(`REG_TOL, 8'h00);
	endtask
	task t_counts;
		logic [14:0] c0;
		logic [14:0] c1;
		c0 = rate_count(100000);
		c1 = rate_count(103125);
		wr(`REG_G0_LO, c0[7:0]);
		wr(`REG_G0_HI, {1'b1, c0[14:8]});
		wr(`REG_G1_LO, c1[7:0]);
		wr(`REG_G1_HI, {1'b1, c1[14:8]});
		wr(`REG_TOL, 8'hFF);
		rd_chk(`REG_G0_LO, 8'h00);
		rd_chk(`REG_G0_HI, 8'hB2);
		rd_chk(`REG_G1_LO, 8'h90);
		rd_chk(`REG_G1_HI, 8'hB3);
		rd_chk(`REG_TOL, 8'hFF);
		no_lock(0);
	endtask
	// 8 and 1 divider pair, restart, reference off, tolerance nibbles
	task t_groups;
		wr(`REG_CHAN_SEL, 8'h00);
		setup(8'hF2, 16'h8004, 16'h0004, 8'h02);
		wait_lock(0, 1'b1);
		`CHECK(grp[0], 1'b0)
		`CHECK(div[1:0], 2'h3)
		`CHECK(trim[4:0] - 5'h0F < 5'h04, 1'b1)
		wr(`REG_CDR_RESET, 8'h0C);
		`CHECK(lock[0], 1'b0)
		wr(`REG_CDR_RESET, 8'h00);
		wait_lock(0, 1'b1);
		wr(`REG_REF_MODE, 8'h00);
		no_lock(0);
		wr(`REG_G0_HI, 8'h00);
		wr(`REG_G1_LO, 8'h0C);
		wr(`REG_G1_HI, 8'h80);
		wr(`REG_TOL, 8'h0F);
		wr(`REG_REF_MODE, 8'h30);
		restart;
		no_lock(0);
		wr(`REG_TOL, 8'hF0);
		restart;
		wait_lock(0, 1'b1);
		`CHECK(grp[0], 1'b1)
		`CHECK(div[1:0], 2'h0)
	endtask
	// every rate code on channel 1, last entry range mode with a forced divider of 4
	task t_codes;
		logic [3:0] code [9];
		logic [1:0] dv [9];
		code = '{4'h2, 4'h3, 4'h4, 4'h6, 4'hA, 4'hB, 4'hC, 4'hF, 4'h0};
		dv = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h1, 2'h1, 2'h0, 2'h3, 2'h2};
		wr(`REG_CHAN_SEL, 8'h01);
		setup(8'h22, 16'h8004, 16'h8004, 8'hFF);
		for (int i = 0; i < 9; i++)
		begin
			wr(`REG_REF_MODE, i == 8 ? 8'h32 : 8'h30);
			// one entry runs with the false-lock guard enabled, which needs a second window
			wr(`REG_RATE_STD, {code[i], i == 3 ? 4'h0 : 4'h2});
			restart;
			wait_lock(1, 1'b1);
			`CHECK(div[3:2], dv[i])
			if (i < 8)
				`CHECK(trim[9:5] - {1'b0, code[i]} < 5'h04, 1'b1)
		end
		wr(`REG_CHAN_SEL, 8'h00);
		rd_chk(`REG_RATE_STD, 8'hF2);
		`CHECK(lock[0], 1'b1)
	endtask
	// broadcast a narrower tolerance: channel 0 loses lock, channel 1 holds the value too
	task t_drop;
		wr(`REG_CHAN_SEL, 8'h04);
		wr(`REG_TOL, 8'h70);
		wait_lock(0, 1'b0);
		wr(`REG_CHAN_SEL, 8'h01);
		rd_chk(`REG_TOL, 8'h70);
	endtask
	task finish_test;
		if (n_fail == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// run comes to about 35k cycles; the limit leaves headroom
	initial
	begin
		#1_900_000;
		n_fail++;
		finish_test;
	end
	initial
	begin
		n_fail = 0;
		n_checks = 0;
		i_rst_n = 1'b0;
		tick_ph = 1'b0;
		tick_en = 4'h0;
		repeat (5) @(posedge i_clock);
		#1;
		i_rst_n = 1'b1;
		t_reset;
		tick_en = 4'h3;
		t_counts;
		t_groups;
		t_codes;
		t_drop;
		finish_test;
	end
endmodule
`default_nettype wire
